// ### pkg/dss_pkg.sv
// Shared constants and types of the dual-slope conversion sequencer
package dss_pkg;

  // ==========================================================================
  // Sequencer phases
  // ==========================================================================
  typedef enum logic [1:0] {
    DSS_INTEGRATOR_ZEROING,   // Integrator output driven back to zero
    DSS_OFFSET_NULLING,       // Offsets stored on the capacitor
    DSS_SIGNAL_INTEG,         // Fixed-length input integration
    DSS_REFERENCE_RAMP        // Reference deintegration
  } dss_phase_t;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic input_pair;         // Internal inputs tied to the signal pins
    logic common_short;       // Internal inputs shorted to analog common
    logic null_loop;          // Feedback loop round integrator and comparator
    logic ref_pos;            // Reference applied with positive polarity
    logic ref_neg;            // Reference applied with negative polarity
    logic zeroing;            // Integrator zeroing switch
  } dss_switch_t;

  typedef struct packed {
    logic        over_range;  // Deintegration hit its maximum
    logic        negative;    // Held sign of the input
    logic [15:0] bcd;         // Four decades of the count
  } dss_reading_t;

  // ==========================================================================
  // Counting, in BCD count values
  // ==========================================================================
  localparam int          DIGITS          = 4;          // Decades per counter
  localparam int          OSC_PER_COUNT   = 2;          // Oscillator periods per count
  localparam logic [15:0] CYCLE_LAST      = 16'h7999;   // 8000 counts per cycle
  localparam logic [15:0] INTEG_LAST      = 16'h1999;   // 2000 counts of integration
  localparam logic [15:0] RAMP_LAST       = 16'h3999;   // 4000 counts of deintegration
  localparam logic [15:0] RAMP_FULL       = 16'h4000;   // Reading on overrange
  localparam logic [15:0] ZEROING_LAST    = 16'h0399;   // 400 counts of zeroing at most
  localparam logic [15:0] BCD_ZERO        = 16'h0000;   // Counter cleared
  localparam int          NULLING_MIN     = 1600;       // Least offset nulling counts
  localparam int          INTEG_CLOCKS    = 4000;       // Oscillator clocks of integration
  localparam int          CYCLE_CLOCKS    = 16000;      // Oscillator clocks per whole cycle

  // ==========================================================================
  // Register map (byte addresses) and fields
  // ==========================================================================
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  REG_IRQ_STATUS  = 8'h00;      // Sticky events, read only
  localparam logic [7:0]  REG_IRQ_CLEAR   = 8'h04;      // Write one to clear
  localparam logic [7:0]  REG_IRQ_ENABLE  = 8'h08;      // Event enables
  localparam logic [7:0]  REG_CONTROL     = 8'h0c;      // Run control
  localparam logic [7:0]  REG_READING     = 8'h10;      // Latest conversion
  localparam logic [7:0]  REG_PHASE       = 8'h14;      // Live sequencer state
  localparam int          EV_DONE         = 0;          // Conversion finished
  localparam int          EV_OVER         = 1;          // Conversion overranged
  localparam int          EV_W            = 2;
  localparam int          CTL_RUN         = 0;          // Sequencer runs when set
  localparam logic        CTL_RUN_RESET   = 1'b1;
  localparam int          RD_NEG          = 16;         // Sign field of reading
  localparam int          RD_OVER         = 17;         // Overrange field of reading
  localparam int          PH_CYCLE_LSB    = 16;         // Cycle count field of phase

endpackage : dss_pkg

// ### design/dss_decade_counter.sv
// Cascaded BCD decade counter with synchronous clear
`timescale 1ns/10ps
module dss_decade_counter #(
  parameter int DIGITS = 4              // Number of decades
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clear,   // Load zero, wins over inc
  input  wire logic                  inc,     // Advance one count
  output logic      [4*DIGITS-1:0]   value    // BCD value, digit 0 lowest
);

  logic [DIGITS:0] carry;                     // Carry into each decade

  assign carry[0] = inc;

  // ==========================================================================
  // One decade per digit
  // ==========================================================================
  generate
    for (genvar d = 0; d < DIGITS; d++) begin : g_digit
      logic [3:0] digit_reg;                  // This decade
      assign carry[d+1] = carry[d] && (digit_reg == 4'h9);
      assign value[4*d +: 4] = digit_reg;
      // Count up, roll over from nine to zero
      always_ff @(posedge sys_clk) begin
        if (sys_rst || clear) begin
          digit_reg <= 4'h0;
        end else if (carry[d]) begin
          digit_reg <= (digit_reg == 4'h9) ? 4'h0 : digit_reg + 4'h1;
        end
      end
    end
  endgenerate

endmodule : dss_decade_counter

// ### design/dss_sequencer.sv
// Phase sequencer, reading latch and register slave of a dual-slope converter
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
// Operation
// - Phases repeat in fixed order, zeroing only after an overrange
// - Decade counters advance at half oscillator rate
// - Every cycle lasts exactly 8000 counts
// - Signal integration lasts fixed 2000 counts
// - Integrator zeroing lasts variable, bounded counts
// - Nulling gets 1600 plus unused counts
// - Nulling spans 1600 up to 5998 counts, 8000 after reset or restart
// - Nulling opens inputs, shorts common, closes loop
// - Integration opens loop, connects signal pair
// - Sign sampled at end of integration
// - Reference applied opposite to held sign
// - Deintegration ends on zero crossing, 1-4000
// - Reading is deintegration count with sign
// - Hold freezes displayed reading, conversion continues
module dss_sequencer (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        comp_pin,      // Comparator, high when above zero
  input  wire logic                        hold_pin,      // Display freeze request
  input  wire logic [dss_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  output dss_pkg::dss_switch_t             switch_ctl,    // Analog switch groups
  output dss_pkg::dss_reading_t            display,       // Displayed reading
  output logic                             irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  dss_pkg::dss_phase_t   phase_reg;          // Current phase
  dss_pkg::dss_phase_t   phase_next;         // Next phase
  dss_pkg::dss_reading_t result_reg;         // Latest conversion
  dss_pkg::dss_reading_t display_reg;        // Reading shown outside
  logic [1:0]            comp_sync_reg;      // Comparator synchroniser
  logic [1:0]            hold_sync_reg;      // Hold synchroniser
  logic                  comp_s;             // Synchronised comparator
  logic                  hold_s;             // Synchronised hold
  logic                  tick_reg;           // Divide-by-two count enable
  logic                  sign_pos_reg;       // Held sign, one when positive
  logic                  zero_start_reg;     // Comparator at zeroing entry
  logic                  run_reg;            // Sequencer enable
  logic [dss_pkg::EV_W-1:0] ev_status_reg;   // Sticky events
  logic [dss_pkg::EV_W-1:0] ev_enable_reg;   // Event enables
  logic [dss_pkg::EV_W-1:0] ev_set;          // Events this cycle
  logic [15:0]           cycle_val;          // Counts into the cycle
  logic [15:0]           ramp_val;           // Counts into ramp or zeroing
  logic                  cycle_clear;
  logic                  ramp_clear;
  logic                  ramp_inc;
  logic                  crossed;            // Comparator left the held sign
  logic                  ramp_end;           // Deintegration finishes
  logic                  ramp_over;          // Finished at its maximum
  logic [31:0]           rdata_next;
  assign comp_s = comp_sync_reg[1];
  assign hold_s = hold_sync_reg[1];

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Two flops per pin, only the second one is read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      comp_sync_reg <= 2'h0;
      hold_sync_reg <= 2'h0;
    end else begin
      comp_sync_reg <= {comp_sync_reg[0], comp_pin};
      hold_sync_reg <= {hold_sync_reg[0], hold_pin};
    end
  end

  // ==========================================================================
  // Count clock and counters
  // ==========================================================================
  // One count every two oscillator periods
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
    end
  end

  // Cycle counter wraps after the last count, so length never varies
  assign cycle_clear = !run_reg || (tick_reg && cycle_val == dss_pkg::CYCLE_LAST);
  // Phase counter only runs in deintegration and zeroing
  assign ramp_inc    = tick_reg && (phase_reg == dss_pkg::DSS_REFERENCE_RAMP ||
                                    phase_reg == dss_pkg::DSS_INTEGRATOR_ZEROING);
  assign ramp_clear  = !run_reg || ramp_end ||
                       phase_reg == dss_pkg::DSS_SIGNAL_INTEG ||
                       phase_reg == dss_pkg::DSS_OFFSET_NULLING;

  dss_decade_counter #(.DIGITS (dss_pkg::DIGITS)) u_cycle_counter (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (cycle_clear),
    .inc     (tick_reg && run_reg),
    .value   (cycle_val)
  );

  dss_decade_counter #(.DIGITS (dss_pkg::DIGITS)) u_ramp_counter (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clear   (ramp_clear),
    .inc     (ramp_inc),
    .value   (ramp_val)
  );

  // ==========================================================================
  // Phase sequencing
  // ==========================================================================
  // Integrator back across zero once it leaves the held side
  assign crossed   = (comp_s != sign_pos_reg);
  // Deintegration ends on the crossing or at its full count
  assign ramp_end  = tick_reg && phase_reg == dss_pkg::DSS_REFERENCE_RAMP &&
                     ((crossed && ramp_val != dss_pkg::BCD_ZERO) ||
                      ramp_val == dss_pkg::RAMP_LAST);
  assign ramp_over = ramp_end && !(crossed && ramp_val != dss_pkg::BCD_ZERO);

  // Next phase
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      dss_pkg::DSS_INTEGRATOR_ZEROING: begin
        // Ends when the integrator crosses zero or at the limit
        if (tick_reg && (comp_s != zero_start_reg ||
                         ramp_val == dss_pkg::ZEROING_LAST)) begin
          phase_next = dss_pkg::DSS_OFFSET_NULLING;
        end
      end
      dss_pkg::DSS_OFFSET_NULLING: begin
        // Absorbs every count left until the cycle wraps
        if (tick_reg && cycle_val == dss_pkg::CYCLE_LAST) begin
          phase_next = dss_pkg::DSS_SIGNAL_INTEG;
        end
      end
      dss_pkg::DSS_SIGNAL_INTEG: begin
        // Fixed length from the cycle start
        if (tick_reg && cycle_val == dss_pkg::INTEG_LAST) begin
          phase_next = dss_pkg::DSS_REFERENCE_RAMP;
        end
      end
      dss_pkg::DSS_REFERENCE_RAMP: begin
        // Zeroing only after an overranged conversion
        if (ramp_end) begin
          phase_next = ramp_over ? dss_pkg::DSS_INTEGRATOR_ZEROING
                                 : dss_pkg::DSS_OFFSET_NULLING;
        end
      end
    endcase
    if (!run_reg) begin
      phase_next = dss_pkg::DSS_OFFSET_NULLING;
    end
  end

  // Phase register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg <= dss_pkg::DSS_OFFSET_NULLING;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Sign held from the end of integration through deintegration
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sign_pos_reg <= 1'b1;
    end else if (phase_reg == dss_pkg::DSS_SIGNAL_INTEG &&
                 phase_next == dss_pkg::DSS_REFERENCE_RAMP) begin
      sign_pos_reg <= comp_s;
    end
  end

  // Comparator side noted on entry to zeroing
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      zero_start_reg <= 1'b0;
    end else if (ramp_over) begin
      zero_start_reg <= comp_s;
    end
  end

  // ==========================================================================
  // Switch decode
  // ==========================================================================
  // One control per switch group
  always_comb begin
    switch_ctl.common_short = (phase_reg == dss_pkg::DSS_OFFSET_NULLING);
    switch_ctl.null_loop    = (phase_reg == dss_pkg::DSS_OFFSET_NULLING);
    switch_ctl.input_pair   = (phase_reg == dss_pkg::DSS_SIGNAL_INTEG);
    switch_ctl.zeroing      = (phase_reg == dss_pkg::DSS_INTEGRATOR_ZEROING);
    // Reference opposes the held input sign
    switch_ctl.ref_neg      = (phase_reg == dss_pkg::DSS_REFERENCE_RAMP) && sign_pos_reg;
    switch_ctl.ref_pos      = (phase_reg == dss_pkg::DSS_REFERENCE_RAMP) && !sign_pos_reg;
  end

  // ==========================================================================
  // Readings
  // ==========================================================================
  // Latest result, full count on overrange
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_reg <= '0;
    end else if (ramp_end) begin
      result_reg.bcd        <= ramp_over ? dss_pkg::RAMP_FULL : ramp_val;
      result_reg.negative   <= !sign_pos_reg;
      result_reg.over_range <= ramp_over;
    end
  end

  // Displayed copy, frozen while hold is asserted
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      display_reg <= '0;
    end else if (ramp_end && !hold_s) begin
      display_reg.bcd        <= ramp_over ? dss_pkg::RAMP_FULL : ramp_val;
      display_reg.negative   <= !sign_pos_reg;
      display_reg.over_range <= ramp_over;
    end
  end
  assign display = display_reg;

  // ==========================================================================
  // Registers and interrupt
  // ==========================================================================
  assign ev_set = {ramp_over, ramp_end};

  // Sticky events, a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_status_reg <= '0;
    end else if (reg_wr && reg_addr == dss_pkg::REG_IRQ_CLEAR) begin
      ev_status_reg <= (ev_status_reg & ~reg_wdata[dss_pkg::EV_W-1:0]) | ev_set;
    end else begin
      ev_status_reg <= ev_status_reg | ev_set;
    end
  end

  // Writable control and enable, one register per write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_enable_reg <= '0;
      run_reg       <= dss_pkg::CTL_RUN_RESET;
    end else if (reg_wr && reg_addr == dss_pkg::REG_IRQ_ENABLE) begin
      ev_enable_reg <= reg_wdata[dss_pkg::EV_W-1:0];
    end else if (reg_wr && reg_addr == dss_pkg::REG_CONTROL) begin
      run_reg <= reg_wdata[dss_pkg::CTL_RUN];
    end
  end

  // Read mux, unmapped and write-only read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr)
      dss_pkg::REG_IRQ_STATUS: rdata_next[dss_pkg::EV_W-1:0] = ev_status_reg;
      dss_pkg::REG_IRQ_ENABLE: rdata_next[dss_pkg::EV_W-1:0] = ev_enable_reg;
      dss_pkg::REG_CONTROL:    rdata_next[dss_pkg::CTL_RUN]  = run_reg;
      dss_pkg::REG_READING: begin
        rdata_next[15:0]             = result_reg.bcd;
        rdata_next[dss_pkg::RD_NEG]  = result_reg.negative;
        rdata_next[dss_pkg::RD_OVER] = result_reg.over_range;
      end
      dss_pkg::REG_PHASE: begin
        rdata_next[1:0]   = phase_reg;
        rdata_next[31:16] = cycle_val;
      end
      default:                 rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // Level interrupt from enabled sticky events
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_status_reg & ev_enable_reg);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [15:0] phase_clk_reg;                // Clocks spent in the phase
  logic [15:0] cycle_clk_reg;                // Clocks since integration began
  logic        cycle_seen_reg;               // A whole cycle was timed

  // Helper timers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_clk_reg  <= 16'h0000;
      cycle_clk_reg  <= 16'h0000;
      cycle_seen_reg <= 1'b0;
    end else begin
      phase_clk_reg <= (phase_next != phase_reg) ? 16'h0000 : phase_clk_reg + 16'h0001;
      if (phase_next == dss_pkg::DSS_SIGNAL_INTEG && phase_reg != phase_next) begin
        cycle_clk_reg  <= 16'h0000;
        cycle_seen_reg <= run_reg;
      end else begin
        cycle_clk_reg <= cycle_clk_reg + 16'h0001;
      end
      if (!run_reg) begin
        cycle_seen_reg <= 1'b0;
      end
    end
  end

  phase_order_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run_reg && phase_reg == dss_pkg::DSS_SIGNAL_INTEG && phase_next != phase_reg)
      |-> phase_next == dss_pkg::DSS_REFERENCE_RAMP)
    else $error("integration not followed by deintegration");
  count_rate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ramp_inc |=> !ramp_inc)
    else $error("counter advanced on two clocks in a row");
  cycle_length_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cycle_seen_reg && run_reg && phase_next == dss_pkg::DSS_SIGNAL_INTEG &&
     phase_reg != phase_next) |-> cycle_clk_reg == dss_pkg::CYCLE_CLOCKS - 1)
    else $error("cycle length not 16000 clocks");
  integ_length_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run_reg && phase_reg == dss_pkg::DSS_SIGNAL_INTEG && phase_next != phase_reg)
      |-> phase_clk_reg == dss_pkg::INTEG_CLOCKS - 1)
    else $error("integration not 4000 clocks");
  zeroing_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    phase_reg == dss_pkg::DSS_INTEGRATOR_ZEROING |-> ramp_val <= dss_pkg::ZEROING_LAST)
    else $error("zeroing ran past its limit");
  nulling_min_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run_reg && phase_reg == dss_pkg::DSS_OFFSET_NULLING && phase_next != phase_reg)
      |-> phase_clk_reg >= 16'(2 * dss_pkg::NULLING_MIN - 1))
    else $error("offset nulling shorter than 1600 counts");
  null_switch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    phase_reg == dss_pkg::DSS_OFFSET_NULLING
      |-> (switch_ctl.common_short && switch_ctl.null_loop && !switch_ctl.input_pair))
    else $error("nulling switches wrong");
  sign_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == dss_pkg::DSS_REFERENCE_RAMP && $past(phase_reg) ==
     dss_pkg::DSS_REFERENCE_RAMP) |-> $stable(sign_pos_reg))
    else $error("sign changed during deintegration");
  ref_polarity_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (phase_reg == dss_pkg::DSS_REFERENCE_RAMP && $past(phase_reg) != phase_reg)
      |-> (switch_ctl.ref_neg == $past(comp_s) && switch_ctl.ref_pos == !$past(comp_s)))
    else $error("reference polarity not opposite to sign");
  reading_value_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ramp_end && !ramp_over) |=> result_reg.bcd == $past(ramp_val))
    else $error("reading differs from deintegration count");
  hold_freeze_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hold_s |=> $stable(display_reg))
    else $error("display changed under hold");
  over_zeroing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (run_reg && ramp_over) |=> (phase_reg == dss_pkg::DSS_INTEGRATOR_ZEROING &&
                                result_reg.over_range))
    else $error("overrange not followed by zeroing");

endmodule : dss_sequencer

// ### bench/dss_front_model.sv
// Behavioural analog front end: integrator and comparator
`timescale 1ns/10ps
module dss_front_model (
  input  wire logic                 sys_clk,
  input  wire dss_pkg::dss_switch_t switch_ctl,  // Switch groups from the sequencer
  input  wire logic signed [31:0]   vin,         // Input level in reading counts
  output logic                      comp_pin     // High while integrator above zero
);
  int acc = 0;  // Integrator level
  // ==========================================================================
  // Integrator: input per clock, reference 2000 per clock, loop or zeroing empties
  always @(posedge sys_clk) begin
    if (switch_ctl.input_pair)
      acc <= acc + vin;
    else if (switch_ctl.ref_pos)
      acc <= acc + 2000;
    else if (switch_ctl.ref_neg)
      acc <= acc - 2000;
    else if (switch_ctl.null_loop | switch_ctl.zeroing)
      acc <= 0;
  end
  // Comparator
  assign comp_pin = acc > 0;
endmodule : dss_front_model

// ### bench/testbench.sv
// Self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
module testbench;
  logic                  sys_clk = 1'b0, sys_rst = 1'b1, hold_pin = 1'b0;
  logic                  reg_wr = 1'b0, reg_rd = 1'b0, comp_pin, irq;
  logic [7:0]            reg_addr = 8'h00;
  logic [31:0]           reg_wdata = 32'h0, reg_rdata;
  dss_pkg::dss_switch_t  switch_ctl, sint, sref, saft;  // Live, in integration, ramp, after
  dss_pkg::dss_reading_t display, kept;
  int                    vin = 0, n_mismatch = 0, comparisons = 0, ni, nr;
  longint                t_last = 0;  // Start of previous integration
  // ==========================================================================
  dss_sequencer u_dss_sequencer (.sys_clk, .sys_rst, .comp_pin, .hold_pin, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .switch_ctl, .display, .irq);
  dss_front_model u_dss_front_model (.sys_clk, .switch_ctl, .vin, .comp_pin);
  initial forever #50 sys_clk = ~sys_clk;
  // Comparison bookkeeping
  task automatic check(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : check
  function automatic bit near(input int a, input int b);
    return (a - b) <= 3 && (b - a) <= 3;
  endfunction : near
  function automatic int bcd2i(input logic [15:0] b);
    return b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0];
  endfunction : bcd2i
  // Bus cycles, driven just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data taken at the edge that closes the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check(reg_rdata === e, m);
  endtask : rd
  task automatic clr;
    wr(8'h04, 32'h3);
    repeat (2) @(posedge sys_clk);
    check(irq === 1'b0, "irq after clear");
  endtask : clr
  // One conversion, phase lengths in clocks
  task automatic conv(input int v);
    vin <= v;
    for (int k = 0; k < 20000 && switch_ctl.input_pair !== 1'b1; k++) @(negedge sys_clk);
    check(switch_ctl.input_pair === 1'b1, "no integration");
    if (t_last != 0) check(($time - t_last) === 64'd1600000, "cycle length");
    t_last = $time;
    sint = switch_ctl;
    for (ni = 0; switch_ctl.input_pair === 1'b1 && ni < 9000; ni++) @(negedge sys_clk);
    sref = switch_ctl;
    for (nr = 0; (sref.ref_pos | sref.ref_neg) === 1'b1 && nr < 9000; nr++) begin
      @(negedge sys_clk) sref = switch_ctl;
    end
    saft = switch_ctl;
    repeat (4) @(posedge sys_clk);
  endtask : conv
  // ==========================================================================
  task automatic test_reset;
    @(posedge sys_clk);
    check(switch_ctl === 6'b011000, "nulling after reset");
    rd(8'h0c, 32'h1, "run bit");
    rd(8'h08, 32'h0, "enable bits");
    rd(8'h30, 32'h0, "unmapped read");
    $display("reset test done");
  endtask : test_reset
  task automatic test_positive;
    wr(8'h08, 32'h3);
    conv(1234);
    check(sint === 6'b100000 && ni === 4000, "integration");
    check(near(nr / 2, 1234) && display.negative === 1'b0, "positive ramp");
    check(near(bcd2i(display.bcd), 1234) && irq === 1'b1, "positive value");
    check(saft === 6'b011000, "nulling follows ramp");
    clr();
    $display("positive test done");
  endtask : test_positive
  task automatic test_negative;
    conv(-567);
    check(near(bcd2i(display.bcd), 567) && display.negative === 1'b1, "negative");
    clr();
    $display("negative test done");
  endtask : test_negative
  task automatic test_hold;
    kept = display;
    hold_pin <= 1'b1;
    wr(8'h08, 32'h0);
    conv(300);
    check(display === kept && near(nr / 2, 300) && irq === 1'b0, "frozen");
    rd(8'h00, 32'h1, "done status");
    clr();
    wr(8'h08, 32'h3);
    hold_pin <= 1'b0;
    $display("hold test done");
  endtask : test_hold
  task automatic test_overrange;
    conv(5000);
    check(nr === 8000 && display === {1'b1, 1'b0, 16'h4000}, "overrange");
    check(saft.zeroing === 1'b1 && irq === 1'b1, "zeroing next");
    rd(8'h00, 32'h3, "overrange status");
    rd(8'h10, 32'h0002_4000, "overrange reading");
    clr();
    $display("overrange test done");
  endtask : test_overrange
  task automatic test_stop;
    wr(8'h0c, 32'h0);
    rd(8'h14, 32'h0000_0001, "stopped in nulling");
    check(switch_ctl === 6'b011000, "stopped switches");
    rd(8'h0c, 32'h0, "run bit cleared");
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h1, "run bit restored");
    $display("stop test done");
  endtask : test_stop
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_positive();
    test_negative();
    test_hold();
    test_overrange();
    test_stop();
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
  task automatic stop_test;
    $display("%0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
endmodule : testbench
